/* logic/bus_phy_master_repeater_mode.sv */
// master and repeater mode line relay with power-fail filter
`timescale 1ns/1ps
`default_nettype none
`include "line_relay_map.svh"
module bus_phy_master_repeater_mode #(
    parameter logic [16:0] PF_RX_CYC = 17'(`PF_RX_CYC),
    parameter logic [16:0] PF_ON_CYC = 17'(`PF_ON_CYC),
    parameter logic [16:0] PF_HOLD_CYC = 17'(`PF_HOLD_CYC),
    parameter logic [16:0] PF_OFF_CYC = 17'(`PF_OFF_CYC)
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic external_reset_low_i,
    input wire logic master_mode_flag_i,
    input wire logic [3:0] slave_profile_code_i,
    input wire logic [3:0] loopback_delay_code_i,
    input wire logic tx_data_i,
    input wire logic line_rx_i,
    input wire logic line_positive_sense_i,
    output logic line_tx_o,
    output logic receiver_enable_o,
    output logic rx_data_o,
    output logic line_power_fail_out_o
);
    import line_relay_pkg::*;

    localparam logic [10:0] HALF_C = 11'(`HALF_BIT_CYC);
    localparam logic [10:0] FULL_C = 11'(`FULL_BIT_CYC);
    localparam logic [10:0] JIT_C = 11'(`JITTER_CYC);
    localparam logic [10:0] HALF_LO = 11'(`HALF_BIT_CYC - 2 * `JITTER_CYC);
    localparam logic [10:0] FULL_LO = 11'(`FULL_BIT_CYC - 2 * `JITTER_CYC);
    localparam logic [10:0] GAP_C = 11'(`ERR_GAP_CYC);
    localparam logic [9:0] GLT_C = 10'(`GLITCH_CYC);
    localparam logic [9:0] TXI_C = 10'(`TX_IDLE_CYC);

    function automatic relay_mode_t decode_mode(
        input logic flag,
        input logic [3:0] code
    );
        if (!flag)
            return mode_off;
        else if (code <= `PROFILE_M1_MAX)
            return mode_master1;
        else if (code == `PROFILE_REPEATER)
            return mode_repeater;
        else
            return mode_master2;
    endfunction

    logic ext_n_s1, ext_n_s2;
    logic rx_s1, rx_s2;
    logic tx_s1, tx_s2, tx_s3;
    logic ps_s1, ps_s2;
    logic rst;
    relay_mode_t mode;
    logic [3:0] lb_code;
    logic loopback;
    logic [9:0] tx_act_cnt;
    logic transmitting;
    logic rx_on;
    logic rx_gated;
    logic [3:0] code_eff;
    logic rx_del;
    logic rx_prev;
    logic in_edge;

    // pins are asynchronous: two flops each before use
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            ext_n_s1 <= 1'b1;
            ext_n_s2 <= 1'b1;
            rx_s1 <= 1'b0;
            rx_s2 <= 1'b0;
            tx_s1 <= 1'b0;
            tx_s2 <= 1'b0;
            tx_s3 <= 1'b0;
            ps_s1 <= 1'b0;
            ps_s2 <= 1'b0;
        end
        else
        begin
            ext_n_s1 <= external_reset_low_i;
            ext_n_s2 <= ext_n_s1;
            rx_s1 <= line_rx_i;
            rx_s2 <= rx_s1;
            tx_s1 <= tx_data_i;
            tx_s2 <= tx_s1;
            tx_s3 <= tx_s2;
            ps_s1 <= line_positive_sense_i;
            ps_s2 <= ps_s1;
        end
    end

    assign rst = sys_rst_i | ~ext_n_s2;

    // mode is taken only while in reset, so the flag and codes must be
    // settled before release; later changes need another reset
    always_ff @(posedge clk_i)
    begin
        if (rst)
        begin
            mode <= decode_mode(master_mode_flag_i, slave_profile_code_i);
            lb_code <= loopback_delay_code_i;
        end
    end

    assign loopback = (mode == mode_master1) || (mode == mode_master2);

    // unregistered on purpose: the driver path must add no delay
    assign line_tx_o = tx_data_i;

    // transmit counts as active until one bit time passes without edges
    always_ff @(posedge clk_i)
    begin
        if (rst)
            tx_act_cnt <= 10'h000;
        else if (tx_s2 ^ tx_s3)
            tx_act_cnt <= TXI_C;
        else if (tx_act_cnt != 10'h000)
            tx_act_cnt <= tx_act_cnt - 10'h001;
    end

    assign transmitting = (tx_act_cnt != 10'h000) | (tx_s2 ^ tx_s3);
    assign rx_on = loopback | ~transmitting;
    assign rx_gated = rx_s2 & rx_on;
    assign code_eff = loopback ? lb_code : 4'h0;

    // base loopback time is set by the analog front end; only the
    // programmed extra and the small resync lag are added here
    loopback_delay_line u_delay (
        .clk_i(clk_i),
        .rst_i(rst),
        .code_i(code_eff),
        .din_i(rx_gated),
        .dout_o(rx_del)
    );

    always_ff @(posedge clk_i)
    begin
        if (rst)
            rx_prev <= 1'b0;
        else
            rx_prev <= rx_del;
    end

    assign in_edge = rx_del ^ rx_prev;

    relay_state_t rl_state, next_rl_state;
    logic [10:0] rl_cnt, next_rl_cnt;
    logic [10:0] tgt, next_tgt;
    logic pend, next_pend;
    logic rly, next_rly;
    logic in_half, in_full, bad;

    // output edges sit on a fixed grid lagging the input by the jitter
    // margin; an input edge must land in the window before its slot
    assign in_half = (rl_cnt >= HALF_LO) && (rl_cnt <= HALF_C);
    assign in_full = (rl_cnt >= FULL_LO) && (rl_cnt <= FULL_C);
    assign bad = in_edge ? (pend || !(in_half || in_full))
                         : (!pend && rl_cnt > FULL_C && rly);

    always_comb
    begin
        next_rl_state = rl_state;
        next_rl_cnt = rl_cnt + 11'h001;
        next_tgt = tgt;
        next_pend = pend;
        next_rly = rly;
        case (rl_state)
            rl_idle:
            begin
                next_rl_cnt = 11'h000;
                next_rly = 1'b0;
                if (in_edge)
                begin
                    next_rl_state = rl_run;
                    next_pend = 1'b1;
                    next_tgt = JIT_C;
                end
            end
            rl_run:
            begin
                if (bad)
                begin
                    next_rl_state = rl_break;
                    next_rl_cnt = 11'h000;
                    next_rly = 1'b0;
                    next_pend = 1'b0;
                end
                else
                begin
                    if (pend && rl_cnt == tgt)
                    begin
                        next_rly = !rly;
                        next_pend = 1'b0;
                        next_rl_cnt = 11'h001; // cycles since output edge
                    end
                    if (in_edge)
                    begin
                        next_pend = 1'b1;
                        next_tgt = in_half ? HALF_C : FULL_C;
                    end
                    else if (!pend && rl_cnt > FULL_C)
                        next_rl_state = rl_idle;
                end
            end
            rl_break:
            begin
                next_rly = 1'b0;
                next_pend = 1'b0;
                if (rl_cnt == GAP_C - 11'h001)
                begin
                    next_rl_state = rl_idle;
                    next_rl_cnt = 11'h000;
                end
            end
            default:
            begin
                next_rl_state = rl_idle;
                next_rl_cnt = 11'h000;
                next_pend = 1'b0;
                next_rly = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst)
        begin
            rl_state <= rl_idle;
            rl_cnt <= 11'h000;
            tgt <= 11'h000;
            pend <= 1'b0;
            rly <= 1'b0;
        end
        else
        begin
            rl_state <= next_rl_state;
            rl_cnt <= next_rl_cnt;
            tgt <= next_tgt;
            pend <= next_pend;
            rly <= next_rly;
        end
    end

    logic pf_flt;
    logic [9:0] g_cnt;

    // a new comparator level is taken only after it stood 6 us
    always_ff @(posedge clk_i)
    begin
        if (rst)
        begin
            pf_flt <= 1'b0;
            g_cnt <= 10'h000;
        end
        else if (ps_s2 == pf_flt)
            g_cnt <= 10'h000;
        else if (g_cnt == GLT_C - 10'h001)
        begin
            pf_flt <= ps_s2;
            g_cnt <= 10'h000;
        end
        else
            g_cnt <= g_cnt + 10'h001;
    end

    pf_state_t pf_state, next_pf_state;
    logic [16:0] pf_cnt, next_pf_cnt;
    logic apf_on, pf_force;
    logic next_rx;

    always_comb
    begin
        next_pf_state = pf_state;
        next_pf_cnt = pf_cnt + 17'h00001;
        case (pf_state)
            pf_ok:
            begin
                next_pf_cnt = 17'h00000;
                if (pf_flt)
                    next_pf_state = pf_count;
            end
            pf_count:
            begin
                if (!pf_flt)
                begin
                    next_pf_state = pf_ok;
                    next_pf_cnt = 17'h00000;
                end
                else if (pf_cnt == PF_RX_CYC - 17'h00001)
                begin
                    next_pf_state = pf_rxsig;
                    next_pf_cnt = 17'h00000;
                end
            end
            pf_rxsig:
            begin
                if (!pf_flt)
                begin
                    next_pf_state = pf_ok;
                    next_pf_cnt = 17'h00000;
                end
                else if (pf_cnt == PF_ON_CYC - 17'h00001)
                begin
                    next_pf_state = pf_hold;
                    next_pf_cnt = 17'h00000;
                end
            end
            pf_hold:
            begin
                if (pf_cnt >= PF_HOLD_CYC - 17'h00001)
                begin
                    next_pf_cnt = pf_cnt;
                    if (!pf_flt)
                    begin
                        next_pf_state = pf_release;
                        next_pf_cnt = 17'h00000;
                    end
                end
            end
            pf_release:
            begin
                if (pf_flt)
                begin
                    next_pf_state = pf_hold;
                    next_pf_cnt = 17'h00000;
                end
                else if (pf_cnt == PF_OFF_CYC - 17'h00001)
                begin
                    next_pf_state = pf_ok;
                    next_pf_cnt = 17'h00000;
                end
            end
            default:
            begin
                next_pf_state = pf_ok;
                next_pf_cnt = 17'h00000;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst)
        begin
            pf_state <= pf_ok;
            pf_cnt <= 17'h00000;
        end
        else
        begin
            pf_state <= next_pf_state;
            pf_cnt <= next_pf_cnt;
        end
    end

    assign apf_on = (mode != mode_off)
                    && (pf_state == pf_hold || pf_state == pf_release);
    assign pf_force = (mode == mode_master1)
                      && (pf_state == pf_rxsig || pf_state == pf_hold
                          || pf_state == pf_release);
    assign next_rx = (mode == mode_off) ? 1'b0
                   : pf_force ? 1'b1
                   : (mode == mode_repeater) ? !rly : rly;

    always_ff @(posedge clk_i)
    begin
        if (rst)
        begin
            rx_data_o <= 1'b0;
            receiver_enable_o <= 1'b1;
            line_power_fail_out_o <= 1'b0;
        end
        else
        begin
            rx_data_o <= next_rx;
            receiver_enable_o <= rx_on;
            line_power_fail_out_o <= apf_on;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst);

    sequence s_err_enter;
        rl_state == rl_run && bad;
    endsequence
    sequence s_pf_drop;
        pf_state == pf_rxsig && !pf_flt;
    endsequence
    sequence s_back_idle;
        pf_state == pf_ok ##1 pf_state != pf_rxsig;
    endsequence

    a_tx_passthru: assert property (line_tx_o == tx_data_i)
        else $error("transmit path altered");
    a_rx_polarity: assert property (
        (mode == mode_repeater && !rly) |=> rx_data_o)
        else $error("repeater idle level is not high");
    a_break_entry: assert property (
        s_err_enter |=> (rl_state == rl_break && !rly) [*8])
        else $error("error did not start an inactive break");
    a_break_length: assert property (
        $fell(rl_state == rl_break) |-> $past(rl_cnt) == GAP_C - 11'h001)
        else $error("break gap has wrong length");
    a_resync_grid: assert property (
        (rl_state == rl_run && $changed(rly))
        |-> ($past(rl_cnt) == HALF_C || $past(rl_cnt) == FULL_C
             || $past(rl_cnt) == JIT_C))
        else $error("relayed edge off the bit grid");
    a_rx_disable: assert property (
        (!loopback && transmitting) |=> !receiver_enable_o)
        else $error("receiver on while transmitting without loopback");
    a_loop_enable: assert property (loopback |=> receiver_enable_o)
        else $error("receiver off in loopback mode");
    a_glitch_filter: assert property (
        $changed(pf_flt) |-> $past(g_cnt) == GLT_C - 10'h001)
        else $error("filtered fail level changed too early");
    a_apf_entry: assert property (
        $rose(pf_state == pf_hold) && $past(pf_state) == pf_rxsig
        |-> $past(pf_cnt) == PF_ON_CYC - 17'h00001)
        else $error("hold entered at wrong time");
    a_rx_drop: assert property (s_pf_drop |=> s_back_idle)
        else $error("short fail did not return to idle");
    a_hold_min: assert property (
        (pf_state == pf_release && $past(pf_state) == pf_hold)
        |-> $past(pf_cnt) >= PF_HOLD_CYC - 17'h00001)
        else $error("fail hold shorter than minimum");
    a_off_delay: assert property (
        (pf_state == pf_ok && $past(pf_state) == pf_release)
        |-> $past(pf_cnt) == PF_OFF_CYC - 17'h00001)
        else $error("release delay wrong");
    a_m1_force: assert property (
        pf_force |=> rx_data_o)
        else $error("mode 1 fail not signalled on receive");
    a_apf_pin: assert property (
        apf_on |=> line_power_fail_out_o)
        else $error("power fail pin not high");
endmodule
`default_nettype wire

/* logic/line_relay_map.svh */
// timing counts and code values for the line relay
`ifndef LINE_RELAY_MAP_SVH
`define LINE_RELAY_MAP_SVH
`define CLK_MHZ 125
`define HALF_BIT_NS 3000
`define HALF_BIT_CYC ((`HALF_BIT_NS * `CLK_MHZ) / 1000)
`define FULL_BIT_CYC (2 * `HALF_BIT_CYC)
`define JITTER_NS 480
`define JITTER_CYC ((`JITTER_NS * `CLK_MHZ) / 1000)
`define ERR_GAP_NS 12000
`define ERR_GAP_CYC ((`ERR_GAP_NS * `CLK_MHZ) / 1000)
`define GLITCH_NS 6000
`define GLITCH_CYC ((`GLITCH_NS * `CLK_MHZ + 999) / 1000)
`define TX_IDLE_NS 6000
`define TX_IDLE_CYC ((`TX_IDLE_NS * `CLK_MHZ) / 1000)
`define LB_STEP_NS 125
`define LB_MAX_CODE 15
`define LB_DEPTH ((`LB_MAX_CODE * `LB_STEP_NS * `CLK_MHZ) / 1000 + 1)
`define PF_RX_US 640
`define PF_RX_CYC (`PF_RX_US * `CLK_MHZ)
`define PF_ON_US 64
`define PF_ON_CYC (`PF_ON_US * `CLK_MHZ)
`define PF_HOLD_US 64
`define PF_HOLD_CYC (`PF_HOLD_US * `CLK_MHZ)
`define PF_OFF_US 96
`define PF_OFF_CYC (`PF_OFF_US * `CLK_MHZ)
`define PROFILE_M1_MAX 4'h4
`define PROFILE_REPEATER 4'h5
`endif

/* logic/line_relay_pkg.sv */
// types shared by the line relay
package line_relay_pkg;
    typedef enum logic [1:0] {
        mode_off, mode_master1, mode_master2, mode_repeater
    } relay_mode_t;
    typedef enum logic [1:0] {rl_idle, rl_run, rl_break} relay_state_t;
    typedef enum logic [2:0] {
        pf_ok, pf_count, pf_rxsig, pf_hold, pf_release
    } pf_state_t;
endpackage

/* logic/loopback_delay_line.sv */
// programmable extra delay in the loopback receive path
`timescale 1ns/1ps
`default_nettype none
`include "line_relay_map.svh"
module loopback_delay_line #(
    parameter int DEPTH = `LB_DEPTH
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] code_i,
    input wire logic din_i,
    output logic dout_o
);
    logic [DEPTH-1:0] taps;
    logic [7:0] tap_n;

    // code times 125 ns, rounded to the nearest 8 ns cycle
    function automatic logic [7:0] tap_of(input logic [3:0] code);
        int prod;
        prod = int'(code) * `LB_STEP_NS * `CLK_MHZ;
        return 8'((prod + 500) / 1000);
    endfunction

    assign tap_n = tap_of(code_i);
    assign dout_o = (tap_n == 8'h00) ? din_i : taps[tap_n - 8'h01];

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            taps <= '0;
        else
            taps <= {taps[DEPTH-2:0], din_i};
    end

    a_delay_step: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (code_i == 4'h1 && $past(code_i, 16) == 4'h1)
        |-> dout_o == $past(din_i, 16))
        else $error("one step of loopback delay is not 16 cycles");
    a_delay_zero: assert property (
        @(posedge clk_i) disable iff (rst_i)
        code_i == 4'h0 |-> dout_o == din_i)
        else $error("code zero adds delay");
endmodule
`default_nettype wire

/* tb/bus_phy_master_repeater_mode_tb_top.sv */
// self-checking bench for the master and repeater line relay
`timescale 1ns/1ps
`default_nettype none
`include "line_relay_map.svh"
module bus_phy_master_repeater_mode_tb_top;
    import line_relay_pkg::*;
    localparam int LIMIT = 80000;
    localparam logic [15:0] GOOD = 16'h0695;
    logic clk_i;
    logic sys_rst_i;
    logic external_reset_low;
    logic flag;
    logic [3:0] prof;
    logic [3:0] code;
    logic tx_data;
    logic line_rx;
    logic sense;
    logic line_tx;
    logic rx_en;
    logic rx_data;
    logic line_power_fail_out;
    int fail_count = 0;
    int checked = 0;
    int cycles = 0;
    int t0 = 0;
    int lat0 = 0;

    // the analog path loops the transmitter back into the receiver
    assign line_rx = line_tx;

    // power-fail counts shortened: 1000, 400, 300 and 500 cycles
    bus_phy_master_repeater_mode #(
        .PF_RX_CYC(17'h003E8),
        .PF_ON_CYC(17'h00190),
        .PF_HOLD_CYC(17'h0012C),
        .PF_OFF_CYC(17'h001F4)
    ) dut_u (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .external_reset_low_i(external_reset_low),
        .master_mode_flag_i(flag),
        .slave_profile_code_i(prof),
        .loopback_delay_code_i(code),
        .tx_data_i(tx_data),
        .line_rx_i(line_rx),
        .line_positive_sense_i(sense),
        .line_tx_o(line_tx),
        .receiver_enable_o(rx_en),
        .rx_data_o(rx_data),
        .line_power_fail_out_o(line_power_fail_out)
    );

    master_ctrl_model mdl_u (
        .clk_i(clk_i),
        .rx_data_i(rx_data),
        .tx_data_o(tx_data)
    );

    initial
    begin
        clk_i = 1'b0;
        forever
            #4 clk_i = ~clk_i;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
        begin
            $display("ALL TESTS PASSED");
        end
        else
        begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // values are copied when the task is called; the 1 ns wait only delays the compare
    task automatic check(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        #1;
        checked++;
        if (got !== exp)
        begin
            $display("Error %s expected %0h seen %0h", what, exp, got);
            fail_count++;
        end
    endtask

    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            fail_count++;
            $display("Error timeout expected %0d seen %0d", LIMIT, cycles);
            close_out();
        end
    end

    // a registered transmit path lags a cycle and shows up here
    always @(negedge clk_i)
    begin
        checked++;
        if (line_tx !== tx_data)
        begin
            $display("Error line_tx expected %0h seen %0h", tx_data, line_tx);
            fail_count++;
        end
    end

    task automatic do_reset(input logic f, input logic [3:0] p,
        input logic [3:0] c);
        @(posedge clk_i);
        sys_rst_i <= 1'b1;
        code <= c;
        prof <= p;
        @(posedge clk_i);
        flag <= f;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        check("rx in reset", 0, rx_data);
        repeat (3) @(posedge clk_i);
        mdl_u.edges.delete();
    endtask

    task automatic wait_to(input int t);
        while (mdl_u.cyc - t0 < t)
            @(posedge clk_i);
    endtask

    task automatic run(input int odd_at, input int odd_len, input int gap);
        mdl_u.edges.delete();
        mdl_u.send(GOOD, 12, odd_at, odd_len);
        repeat (gap) @(posedge clk_i);
    endtask

    // expected gaps come from the half-bit positions of each level change
    task automatic check_relay(input int cnt);
        int pos[$];
        logic prev;
        prev = 1'b0;
        for (int i = 0; i < 12; i++)
        begin
            if (GOOD[i] != prev)
                pos.push_back(i);
            prev = GOOD[i];
        end
        check("edge count", cnt, mdl_u.edges.size());
        for (int j = 1; j < cnt && j < mdl_u.edges.size(); j++)
            check("edge gap", (pos[j] - pos[j - 1]) * `HALF_BIT_CYC,
                mdl_u.edges[j] - mdl_u.edges[j - 1]);
    endtask

    task automatic pf_long(input logic exp_rx);
        @(posedge clk_i);
        t0 = mdl_u.cyc;
        sense <= 1'b1;
        wait_to(1450);
        sense <= 1'b0;
        wait_to(2100);
        check("apf pending", 0, line_power_fail_out);
        wait_to(2300);
        check("apf on", 1, line_power_fail_out);
        check("rx on fail", exp_rx, rx_data);
        wait_to(2800);
        check("apf hold", 1, line_power_fail_out);
        wait_to(3050);
        check("apf off", 0, line_power_fail_out);
    endtask

    initial
    begin
        sys_rst_i = 1'b1;
        external_reset_low = 1'b1;
        flag = 1'b0;
        prof = 4'h0;
        code = 4'h0;
        sense = 1'b0;
        for (int m = 0; m < 17; m++)
        begin
            do_reset(m < 16, (m < 16) ? 4'(m) : 4'h5, 4'h0);
            check("rx idle", (m == 5), rx_data);
            check("rx enable", 1, rx_en);
            check("apf idle", 0, line_power_fail_out);
        end
        do_reset(1'b1, 4'h0, 4'h0);
        run(-1, 0, 1200);
        check_relay(10);
        lat0 = mdl_u.edges[0] - mdl_u.tx_start;
        run(3, `HALF_BIT_CYC + 40, 1200);
        check_relay(10);
        run(8, 560, 600);
        check_relay(8);
        check("rx break", 0, rx_data);
        run(-1, 0, 1200);
        check_relay(10);
        do_reset(1'b1, 4'h0, 4'hF);
        run(-1, 0, 1200);
        check_relay(10);
        check("loop delay", (15 * `LB_STEP_NS * `CLK_MHZ + 500) / 1000,
            mdl_u.edges[0] - mdl_u.tx_start - lat0);
        do_reset(1'b1, 4'h9, 4'h1);
        run(-1, 0, 1200);
        check_relay(10);
        check("loop step", (`LB_STEP_NS * `CLK_MHZ + 500) / 1000,
            mdl_u.edges[0] - mdl_u.tx_start - lat0);
        do_reset(1'b1, `PROFILE_REPEATER, 4'h0);
        fork
            run(-1, 0, 300);
            begin
                repeat (100) @(posedge clk_i);
                check("rx enable tx", 0, rx_en);
            end
        join
        check("rx enable hold", 0, rx_en);
        repeat (150) @(posedge clk_i);
        check("rx enable back", 1, rx_en);
        check("own relay", 0, mdl_u.edges.size());
        check("rx idle rep", 1, rx_data);
        @(posedge clk_i);
        external_reset_low <= 1'b0;
        repeat (5) @(posedge clk_i);
        check("rx ext reset", 0, rx_data);
        @(posedge clk_i);
        external_reset_low <= 1'b1;
        repeat (6) @(posedge clk_i);
        check("rx ext release", 1, rx_data);
        do_reset(1'b1, 4'h0, 4'h0);
        sense <= 1'b1;
        repeat (500) @(posedge clk_i);
        sense <= 1'b0;
        repeat (1500) @(posedge clk_i);
        check("apf short", 0, line_power_fail_out);
        check("rx short", 0, rx_data);
        @(posedge clk_i);
        t0 = mdl_u.cyc;
        sense <= 1'b1;
        wait_to(1200);
        sense <= 1'b0;
        wait_to(1650);
        check("rx early", 0, rx_data);
        wait_to(1900);
        check("rx fail", 1, rx_data);
        check("apf early", 0, line_power_fail_out);
        wait_to(2100);
        check("rx drop", 0, rx_data);
        check("apf none", 0, line_power_fail_out);
        pf_long(1'b1);
        do_reset(1'b1, 4'h6, 4'h0);
        pf_long(1'b0);
        close_out();
    end
endmodule
`default_nettype wire

/* tb/master_ctrl_model.sv */
// master controller model: drives transmit, logs receive edges
`timescale 1ns/1ps
`default_nettype none
`include "line_relay_map.svh"
module master_ctrl_model (
    input wire logic clk_i,
    input wire logic rx_data_i,
    output logic tx_data_o
);
    int cyc = 0;
    int tx_start = 0;
    int edges[$];
    logic rx_last = 1'b0;
    initial
    begin
        tx_data_o = 1'b0;
    end
    // edge stamps let the bench judge spacing without reading timers
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        rx_last <= rx_data_i;
        if (rx_data_i !== rx_last)
        begin
            edges.push_back(cyc);
        end
    end
    // each bit of lv is one half bit; odd_at stretches one of them
    task automatic send(input logic [15:0] lv, input int n,
        input int odd_at, input int odd_len);
        int len;
        @(posedge clk_i);
        tx_start = cyc;
        for (int i = 0; i < n; i++)
        begin
            len = (i == odd_at) ? odd_len : `HALF_BIT_CYC;
            tx_data_o <= lv[i];
            repeat (len) @(posedge clk_i);
        end
        tx_data_o <= 1'b0;
    endtask
endmodule
`default_nettype wire
